// ==== rxc_pkg.sv ====
package rxc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock output select codes and divide ratios
    localparam logic [1:0] CLK_SEL_OFF = 2'h0;
    localparam logic [1:0] CLK_SEL_DIV3 = 2'h1;
    localparam logic [1:0] CLK_SEL_DIV6 = 2'h2;
    localparam logic [1:0] CLK_SEL_DIV12 = 2'h3;
    localparam logic [3:0] CLK_DIV3 = 4'h3;
    localparam logic [3:0] CLK_DIV6 = 4'h6;
    localparam logic [3:0] CLK_DIV12 = 4'hc;

    ////////////////////////////////////////////////////////////////////////
    // base tick is the oscillator divided by sixteen
    localparam logic [3:0] BASE_DIV_LAST = 4'hf;

    // scaled tick length in base ticks per bit-rate range
    localparam logic [3:0] XSCALE_R0 = 4'h8;
    localparam logic [3:0] XSCALE_R1 = 4'h4;
    localparam logic [3:0] XSCALE_R2 = 4'h2;
    localparam logic [3:0] XSCALE_R3 = 4'h1;

    ////////////////////////////////////////////////////////////////////////
    // defaults for tunable counts, plus the fixed pin count
    localparam int STARTUP_XTICKS_DEF = 32;
    localparam int DEBOUNCE_DEF = 2;
    localparam int BUF_DEPTH_DEF = 2;
    localparam int PIN_COUNT = 12;

    typedef enum logic [3:0] {
        RXC_OFF = 4'h1,
        RXC_STANDBY = 4'h2,
        RXC_STARTUP = 4'h4,
        RXC_ACTIVE = 4'h8
    } rxc_mode_t;

endpackage : rxc_pkg

// ==== rxc_clk_div.sv ====
`timescale 1ns/1ps
module rxc_clk_div (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire logic [1:0] sel_i,
    output logic clk_o
);

    logic [3:0] cnt_q;
    logic tog_q;
    logic p_q;
    logic n_q;
    logic [3:0] div_w;
    logic [3:0] half_last_w;
    logic on_w;
    logic wrap_w;
    logic is3_w;

    assign on_w = run_i && (sel_i != rxc_pkg::CLK_SEL_OFF);
    assign is3_w = sel_i == rxc_pkg::CLK_SEL_DIV3;
    assign div_w = is3_w ? rxc_pkg::CLK_DIV3 :
                   (sel_i == rxc_pkg::CLK_SEL_DIV6) ? rxc_pkg::CLK_DIV6 :
                   rxc_pkg::CLK_DIV12;
    assign half_last_w = {1'b0, div_w[3:1]} - 4'h1;
    assign wrap_w = cnt_q >= (div_w - 4'h1);

    ////////////////////////////////////////////////////////////////////////
    // even ratios toggle at half period, odd one merges both edges
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cnt_q <= 4'h0;
            tog_q <= 1'b0;
            p_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!on_w)
            begin
                cnt_q <= 4'h0;
                tog_q <= 1'b0;
                p_q <= 1'b0;
            end
            else
            begin
                cnt_q <= wrap_w ? 4'h0 : cnt_q + 4'h1;
                if (cnt_q == half_last_w || wrap_w)
                    tog_q <= ~tog_q;
                p_q <= wrap_w;
            end
        end
    end

    // half-cycle stretch gives the divide-by-three its even duty
    always_ff @(negedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            n_q <= 1'b0;
        else if (ce_i)
            n_q <= on_w && p_q;
    end

    assign clk_o = is3_w ? (p_q | n_q) : tog_q;

    a_clk_off_low : assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && !on_w)[*2] |-> !clk_o)
        else $error("clock output not low while stopped");

endmodule : rxc_clk_div

// ==== rxc_buf2.sv ====
`timescale 1ns/1ps
module rxc_buf2 #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push_w;
    logic pop_w;

    assign in_ready_o = cnt_q != FULL;
    assign out_valid_o = cnt_q != '0;
    assign out_data_o = mem_q[rd_q];
    assign push_w = ce_i && in_valid_i && in_ready_o;
    assign pop_w = ce_i && out_valid_o && out_ready_i;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push_w)
                wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
            if (pop_w)
                rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
            if (push_w && !pop_w)
                cnt_q <= cnt_q + 1'b1;
            else if (pop_w && !push_w)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    // storage has no reset, only valid words are ever read
    always_ff @(posedge clk_i)
    begin
        if (push_w)
            mem_q[wr_q] <= in_data_i;
    end

    a_buf_word_held : assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        out_valid_o && !(ce_i && out_ready_i)
        |=> out_valid_o && $stable(out_data_o))
        else $error("buffered word dropped or changed under stall");

    a_buf_full_stall : assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        cnt_q == FULL && !pop_w |=> cnt_q == FULL && !in_ready_o)
        else $error("buffer accepts a word while full");

endmodule : rxc_buf2

// ==== rxc_ctrl.sv ====
`timescale 1ns/1ps
module rxc_ctrl #(
    parameter int STARTUP_XTICKS = rxc_pkg::STARTUP_XTICKS_DEF,
    parameter int DEBOUNCE = rxc_pkg::DEBOUNCE_DEF,
    parameter int BUF_DEPTH = rxc_pkg::BUF_DEPTH_DEF
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic chip_enable_i,
    input wire logic rx_enable_i,
    input wire logic clock_out_select_lo_i,
    input wire logic clock_out_select_hi_i,
    input wire logic rate_select_lo_i,
    input wire logic rate_select_hi_i,
    input wire logic sens_reduce_req_i,
    input wire logic modulation_select_i,
    input wire logic rssi_above_i,
    input wire logic demod_data_i,
    input wire logic osc_amp_ok_i,
    input wire logic digital_supply_ok_i,
    input wire logic data_ready_i,
    output logic mcu_clk_o,
    output logic osc_enable_o,
    output logic rx_path_enable_o,
    output logic rx_ready_o,
    output logic sens_latch_o,
    output logic data_pin_o,
    output logic data_valid_o,
    output logic data_o
);

    localparam logic [15:0] SU_LAST = 16'(STARTUP_XTICKS - 1);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: only the second stage is read
    logic [rxc_pkg::PIN_COUNT-1:0] pins_w;
    logic [rxc_pkg::PIN_COUNT-1:0] meta_q;
    logic [rxc_pkg::PIN_COUNT-1:0] sync_q;

    assign pins_w = {chip_enable_i, rx_enable_i, clock_out_select_hi_i,
                     clock_out_select_lo_i, rate_select_hi_i,
                     rate_select_lo_i, sens_reduce_req_i,
                     modulation_select_i, rssi_above_i, demod_data_i,
                     osc_amp_ok_i, digital_supply_ok_i};

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else if (ce_i)
        begin
            meta_q <= pins_w;
            sync_q <= meta_q;
        end
    end

    logic en_s;
    logic rx_s;
    logic [1:0] csel_s;
    logic [1:0] bit_rate_range;
    logic sense_s;
    logic mod_s;
    logic rssi_s;
    logic demod_s;
    logic amp_ok_s;
    logic supply_ok_s;

    assign {en_s, rx_s, csel_s, bit_rate_range, sense_s, mod_s, rssi_s,
            demod_s, amp_ok_s, supply_ok_s} = sync_q;

    ////////////////////////////////////////////////////////////////////////
    // operating mode
    rxc_pkg::rxc_mode_t st_q;
    rxc_pkg::rxc_mode_t st_d;
    logic [15:0] su_cnt_q;
    logic clk_run_w;
    logic base_tick;
    logic xtick;
    logic su_done_w;

    assign su_done_w = xtick && (su_cnt_q == SU_LAST);

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            rxc_pkg::RXC_OFF,
            rxc_pkg::RXC_STANDBY:
                if (rx_s)
                    st_d = rxc_pkg::RXC_STARTUP;
                else if (en_s)
                    st_d = rxc_pkg::RXC_STANDBY;
                else
                    st_d = rxc_pkg::RXC_OFF;
            rxc_pkg::RXC_STARTUP:
                if (!rx_s)
                    st_d = en_s ? rxc_pkg::RXC_STANDBY : rxc_pkg::RXC_OFF;
                else if (su_done_w)
                    st_d = rxc_pkg::RXC_ACTIVE;
            rxc_pkg::RXC_ACTIVE:
                if (!rx_s)
                    st_d = en_s ? rxc_pkg::RXC_STANDBY : rxc_pkg::RXC_OFF;
            default:
                st_d = rxc_pkg::RXC_OFF;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_q <= rxc_pkg::RXC_OFF;
            su_cnt_q <= 16'h0000;
        end
        else if (ce_i)
        begin
            st_q <= st_d;
            if (st_q != rxc_pkg::RXC_STARTUP)
                su_cnt_q <= 16'h0000;
            else if (xtick)
                su_cnt_q <= su_cnt_q + 16'h0001;
        end
    end

    assign osc_enable_o = st_q != rxc_pkg::RXC_OFF;
    assign rx_path_enable_o = (st_q == rxc_pkg::RXC_STARTUP) ||
                              (st_q == rxc_pkg::RXC_ACTIVE);
    assign rx_ready_o = st_q == rxc_pkg::RXC_ACTIVE;
    // no clock until amplitude and digital supply are both good
    assign clk_run_w = osc_enable_o && amp_ok_s && supply_ok_s;

    ////////////////////////////////////////////////////////////////////////
    // base and scaled ticks
    function automatic logic [3:0] xscale_last(input logic [1:0] range);
        unique case (range)
            2'h0: xscale_last = rxc_pkg::XSCALE_R0 - 4'h1;
            2'h1: xscale_last = rxc_pkg::XSCALE_R1 - 4'h1;
            2'h2: xscale_last = rxc_pkg::XSCALE_R2 - 4'h1;
            2'h3: xscale_last = rxc_pkg::XSCALE_R3 - 4'h1;
        endcase
    endfunction : xscale_last

    logic [3:0] bcnt_q;
    logic [3:0] xcnt_q;
    logic [3:0] xlast_w;
    logic stall_w;

    assign xlast_w = xscale_last(bit_rate_range);
    assign base_tick = clk_run_w && (bcnt_q == rxc_pkg::BASE_DIV_LAST);
    assign xtick = base_tick && (xcnt_q >= xlast_w) && !stall_w;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            bcnt_q <= 4'h0;
            xcnt_q <= 4'h0;
        end
        else if (ce_i)
        begin
            bcnt_q <= clk_run_w ? bcnt_q + 4'h1 : 4'h0;
            if (!clk_run_w || xtick)
                xcnt_q <= 4'h0;
            else if (base_tick && xcnt_q < xlast_w)
                xcnt_q <= xcnt_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // debounce on scaled ticks
    logic [DEBOUNCE-1:0] hist_q;
    logic deb_q;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            hist_q <= '0;
            deb_q <= 1'b0;
        end
        else if (ce_i && xtick)
        begin
            hist_q <= {hist_q[DEBOUNCE-2:0], demod_s};
            if (&hist_q)
                deb_q <= 1'b1;
            else if (~|hist_q)
                deb_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // threshold latch; set wins over any clear in the same cycle
    logic latch_q;
    logic mod_d_q;
    logic mod_rise_w;
    logic latch_set_w;
    logic latch_clr_w;
    logic pass_w;

    assign mod_rise_w = base_tick && mod_s && !mod_d_q;
    // the comparator counts only with the path fully up
    assign latch_set_w = rssi_s && rx_ready_o;
    assign latch_clr_w = mod_rise_w || !rx_path_enable_o;
    // same gate for either modulation: the mode pin only clears it
    assign pass_w = !sense_s || latch_q;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            latch_q <= 1'b0;
            mod_d_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (base_tick)
                mod_d_q <= mod_s;
            latch_q <= latch_set_w || (latch_q && !latch_clr_w);
        end
    end

    assign sens_latch_o = latch_q;

    ////////////////////////////////////////////////////////////////////////
    // data out: level pin plus sampled words through the buffer
    logic data_pin_q;
    logic pend_v_q;
    logic pend_q;
    logic buf_ready_w;

    // a full buffer freezes the sampling rather than drop a word
    assign stall_w = pend_v_q && !buf_ready_w;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            data_pin_q <= 1'b0;
            pend_v_q <= 1'b0;
            pend_q <= 1'b0;
        end
        else if (ce_i)
        begin
            data_pin_q <= rx_ready_o && pass_w && deb_q;
            if (xtick && rx_ready_o)
            begin
                pend_v_q <= 1'b1;
                pend_q <= pass_w && deb_q;
            end
            else if (buf_ready_w)
                pend_v_q <= 1'b0;
        end
    end

    assign data_pin_o = data_pin_q;

    rxc_buf2 #(
        .WIDTH(1),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .in_valid_i(pend_v_q),
        .in_ready_o(buf_ready_w),
        .in_data_i(pend_q),
        .out_valid_o(data_valid_o),
        .out_ready_i(data_ready_i),
        .out_data_o(data_o)
    );

    rxc_clk_div u_div (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .run_i(clk_run_w),
        .sel_i(csel_s),
        .clk_o(mcu_clk_o)
    );

    ////////////////////////////////////////////////////////////////////////
    logic [4:0] gap_q;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            gap_q <= 5'h00;
        else if (ce_i)
            gap_q <= (base_tick || !clk_run_w) ? 5'h00 : gap_q + 5'h01;
    end

    sequence s_mod_rise;
        ce_i && mod_rise_w && !latch_set_w;
    endsequence

    a_base_tick_gap : assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && base_tick |-> gap_q == 5'h0f)
        else $error("base tick spacing is not sixteen cycles");

    a_xtick_on_base : assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        xtick |-> base_tick && !stall_w && xcnt_q >= xlast_w)
        else $error("scaled tick off its base tick count");

    a_latch_sets : assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && rssi_s && st_q == rxc_pkg::RXC_ACTIVE |=> latch_q)
        else $error("threshold latch failed to set");

    a_latch_mod_clear : assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        s_mod_rise |=> !latch_q)
        else $error("mode pulse did not clear latch");

    a_latch_off_clear : assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && !rx_path_enable_o |=> !latch_q)
        else $error("latch held with receive path off");

    a_gate_low : assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && sense_s && !latch_q |=> !data_pin_o)
        else $error("data passed while gated");

    a_startup_len : assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        st_q == rxc_pkg::RXC_STARTUP ##1 st_q == rxc_pkg::RXC_ACTIVE
        |-> $past(su_cnt_q) == SU_LAST)
        else $error("start-up ended at wrong tick count");

    a_off_no_clk : assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && st_q == rxc_pkg::RXC_OFF)[*3] |-> !mcu_clk_o)
        else $error("clock output runs in off mode");

endmodule : rxc_ctrl

// ==== rxc_host_model.sv ====
`timescale 1ns/1ps
module rxc_host_model #(
    parameter int AMP_DELAY = 20
) (
    input wire logic clk_i,
    input wire logic osc_enable_i,
    output logic amp_ok_o
);
    int amp_cnt_q;

    initial
    begin
        amp_ok_o = 1'b0;
        amp_cnt_q = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // amplitude detector: ok only some time after the oscillator starts
    always @(negedge clk_i)
    begin
        if (osc_enable_i !== 1'b1)
        begin
            amp_cnt_q <= 0;
            amp_ok_o <= 1'b0;
        end
        else if (amp_cnt_q == AMP_DELAY)
        begin
            amp_ok_o <= 1'b1;
        end
        else
        begin
            amp_cnt_q <= amp_cnt_q + 1;
        end
    end

endmodule : rxc_host_model

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    logic clk_i;
    logic sys_rst_i;
    logic ce, en, rx, srq, ms, rs, dm, aok, sok, rdy;
    logic [1:0] cs, rt;
    logic mcu, osc, path, rxr, lat, dpin, dval, dat;
    int err_count;
    int checks_done;
    int cycles;
    int hi_ps, per_ps;
    realtime t0;

    rxc_ctrl #(.STARTUP_XTICKS(2)) rxc_ctrl_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
        .chip_enable_i(en), .rx_enable_i(rx),
        .clock_out_select_lo_i(cs[0]), .clock_out_select_hi_i(cs[1]),
        .rate_select_lo_i(rt[0]), .rate_select_hi_i(rt[1]),
        .sens_reduce_req_i(srq), .modulation_select_i(ms),
        .rssi_above_i(rs), .demod_data_i(dm), .osc_amp_ok_i(aok),
        .digital_supply_ok_i(sok), .data_ready_i(rdy),
        .mcu_clk_o(mcu), .osc_enable_o(osc), .rx_path_enable_o(path),
        .rx_ready_o(rxr), .sens_latch_o(lat), .data_pin_o(dpin),
        .data_valid_o(dval), .data_o(dat));

    rxc_host_model rxc_host_model_i (
        .clk_i(clk_i), .osc_enable_i(osc), .amp_ok_o(aok));

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (err_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            tally_and_finish;
        end
    end

    task automatic chk(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_ps(input int got, input int exp);
        checks_done++;
        if (got != exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_ps

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc

    // times one full period of the clock output, in picoseconds
    task automatic measure;
        realtime ta, tb_, tc;
        @(posedge mcu);
        ta = $realtime;
        @(negedge mcu);
        tb_ = $realtime;
        @(posedge mcu);
        tc = $realtime;
        hi_ps = $rtoi((tb_ - ta) * 1000.0 + 0.5);
        per_ps = $rtoi((tc - ta) * 1000.0 + 0.5);
    endtask : measure

    // bounded wait; start-up is a few scaled ticks at most
    task automatic wait_ready;
        int n;
        n = 0;
        while (rxr !== 1'b1 && n < 600)
        begin
            cyc(1);
            n++;
        end
    endtask : wait_ready

    ////////////////////////////////////////////////////////////////////////
    // host pin drivers, all changed on the falling edge
    task automatic mode(input logic e, input logic r);
        @(negedge clk_i);
        en = e;
        rx = r;
    endtask : mode

    task automatic clock_sel(input logic [1:0] s);
        @(negedge clk_i);
        cs = s;
    endtask : clock_sel

    task automatic rate(input logic [1:0] r);
        @(negedge clk_i);
        rt = r;
    endtask : rate

    // grounded request when reduced sensitivity is not wanted
    task automatic sense(input logic req);
        @(negedge clk_i);
        srq = req;
    endtask : sense

    task automatic level(input logic r, input logic d, input logic m);
        @(negedge clk_i);
        rs = r;
        dm = d;
        ms = m;
    endtask : level

    task automatic supply(input logic v);
        @(negedge clk_i);
        sok = v;
    endtask : supply

    task automatic ready(input logic v);
        @(negedge clk_i);
        rdy = v;
    endtask : ready

    // low then high across more than one base tick each, so it is seen
    task automatic mod_pulse;
        @(negedge clk_i);
        ms = 1'b0;
        repeat (40) @(negedge clk_i);
        ms = 1'b1;
        repeat (40) @(negedge clk_i);
        ms = 1'b0;
    endtask : mod_pulse

    task automatic rssi_trip;
        level(1'b1, 1'b1, ms);
        cyc(10);
        level(1'b0, 1'b1, ms);
        cyc(100);
    endtask : rssi_trip

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        err_count = 0;
        checks_done = 0;
        cycles = 0;
        ce = 1'b1;
        {en, rx, cs, rt} = 6'h00;
        {srq, ms, rs, dm, sok, rdy} = 6'h00;
        sys_rst_i = 1'b1;
        cyc(10);
        chk(osc, 1'b0);
        chk(dval, 1'b0);
        sys_rst_i = 1'b0;
        supply(1'b1);
        clock_sel(2'h1);
        cyc(60);
        chk(osc, 1'b0);
        chk(mcu, 1'b0);
        mode(1'b1, 1'b0);
        cyc(40);
        chk(osc, 1'b1);
        chk(path, 1'b0);
        // supply not good: clock must stay quiet
        supply(1'b0);
        cyc(5);
        repeat (20)
        begin
            cyc(1);
            chk(mcu, 1'b0);
        end
        supply(1'b1);
        for (int s = 1; s < 4; s++)
        begin
            clock_sel(2'(s));
            cyc(30);
            measure;
            chk_ps(per_ps, 75000 << (s - 1));
            chk_ps(hi_ps, 37500 << (s - 1));
        end
        clock_sel(2'h0);
        cyc(5);
        repeat (20)
        begin
            cyc(1);
            chk(mcu, 1'b0);
        end
        // reduced sensitivity: request first, then receive enable
        rate(2'h3);
        ready(1'b1);
        sense(1'b1);
        level(1'b0, 1'b1, 1'b0);
        mode(1'b1, 1'b1);
        cyc(6);
        chk(path, 1'b1);
        wait_ready;
        chk(rxr, 1'b1);
        clock_sel(2'h2);
        cyc(30);
        measure;
        chk_ps(per_ps, 150000);
        for (int m = 0; m < 2; m++)
        begin
            level(1'b0, 1'b1, 1'(m));
            cyc(100);
            chk(lat, 1'b0);
            chk(dpin, 1'b0);
            rssi_trip;
            chk(lat, 1'b1);
            chk(dpin, 1'b1);
            level(1'b0, 1'b1, 1'b0);
            cyc(40);
            chk(lat, 1'b1);
            mod_pulse;
            cyc(40);
            chk(lat, 1'b0);
            chk(dpin, 1'b0);
        end
        rssi_trip;
        mode(1'b1, 1'b0);
        cyc(8);
        chk(lat, 1'b0);
        chk(rxr, 1'b0);
        // full sensitivity: data follows the demodulator ungated
        sense(1'b0);
        mode(1'b1, 1'b1);
        wait_ready;
        cyc(100);
        chk(dpin, 1'b1);
        level(1'b0, 1'b0, 1'b0);
        cyc(100);
        chk(dpin, 1'b0);
        for (int r = 0; r < 4; r++)
        begin
            rate(2'(r));
            cyc(300);
            @(posedge dval);
            t0 = $realtime;
            @(posedge dval);
            chk_ps($rtoi(($realtime - t0) * 1000.0 + 0.5),
                (8 >> r) * 16 * 25000);
        end
        // stall the consumer; none of the three held words may be lost
        level(1'b0, 1'b1, 1'b0);
        cyc(100);
        ready(1'b0);
        cyc(200);
        chk(dval, 1'b1);
        level(1'b0, 0, 1'b0);
        cyc(100);
        ready(1'b1);
        for (int k = 0; k < 3; k++)
        begin
            chk(dval, 1'b1);
            chk(dat, 1'b1);
            cyc(1);
        end
        // clock enable low freezes the pins and the mode
        ce = 1'b0;
        mode(1'b1, 1'b0);
        cyc(20);
        chk(path, 1'b1);
        ce = 1'b1;
        cyc(6);
        chk(path, 1'b0);
        tally_and_finish;
    end
endmodule : tb
